// >>> design/dsf_pkg.sv
package dsf_pkg;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_PRM = 8'h04;
    localparam logic [7:0] A_LEN = 8'h08;
    localparam logic [7:0] A_IOLEN = 8'h0C;
    localparam logic [7:0] A_LIMIT = 8'h10;
    localparam logic [7:0] A_BUF = 8'h14;
    localparam logic [7:0] A_REPORT = 8'h18;
    localparam logic [7:0] A_RESULT = 8'h1C;
    localparam logic [7:0] A_WDOG = 8'h20;
    // parameter register field positions
    localparam int P_FB_LO = 0;
    localparam int P_TB_LO = 2;
    localparam int P_AUTO = 4;
    localparam int P_SYNC = 5;
    localparam int P_OPT = 6;
    localparam int P_FAST = 7;
    localparam int P_MULTI = 8;
    localparam int P_NOCHK = 9;
    localparam int P_C1EN = 10;
    localparam int P_C1DEF = 11;
    localparam int PRM_W = 12;
    // byte holding both reaction fields
    localparam logic [7:0] REACT_BYTE = 8'h0A;
    // error codes
    localparam logic [7:0] C_PRM = 8'h01;
    localparam logic [7:0] C_CFG = 8'h02;
    localparam logic [7:0] C_COMBO = 8'h03;
    localparam logic [7:0] C_OUTLEN = 8'h05;
    localparam logic [7:0] C_INLEN = 8'h06;
    localparam logic [7:0] C_CFGGEN = 8'h07;
    localparam logic [7:0] C_BUF = 8'h08;
    localparam logic [7:0] C_BOOT = 8'h09;
    localparam logic [7:0] C_TREG = 8'h0A;
    localparam logic [7:0] C_TTMO = 8'h0B;
    // error arguments
    localparam logic [7:0] A3_HOLD = 8'h01;
    localparam logic [7:0] A3_C1 = 8'h02;
    localparam logic [7:0] A3_MULTI = 8'h06;
    localparam logic [7:0] A3_SYNC = 8'h08;
    localparam logic [7:0] A3_OPT = 8'h0A;
    localparam logic [7:0] A3_BUF = 8'h0B;
    localparam logic [7:0] A3_FAST = 8'h0C;
    localparam logic [7:0] A7_MAXIN = 8'h0D;
    localparam logic [7:0] A7_MAXOUT = 8'h0E;
    localparam logic [7:0] A7_DIAG = 8'h0F;
    localparam logic [7:0] A7_CFGLEN = 8'h10;
    localparam logic [7:0] A7_PRMLEN = 8'h11;
    localparam logic [7:0] A9_IN = 8'h01;
    localparam logic [7:0] A9_OUT = 8'h02;
    localparam logic [7:0] A9_CFG = 8'h03;
    // frame length limits in bytes
    localparam logic [7:0] DIAG_MIN = 8'h10;
    localparam logic [7:0] DIAG_MAX = 8'h40;
    localparam logic [7:0] CFG_MIN = 8'h01;
    localparam logic [7:0] CFG_MAX = 8'hF0;
    localparam logic [7:0] PRM_MIN = 8'h40;
    localparam logic [7:0] PRM_MAX = 8'hE0;
    // reaction encodings
    localparam logic [1:0] R_ABANDON = 2'h0;
    localparam logic [1:0] R_ZERO = 2'h1;
    localparam logic [1:0] R_HOLD = 2'h2;
    // reset values
    localparam logic [15:0] WD_DEF_MS = 16'h0064;
    localparam logic [23:0] LEN_RST = 24'h40_01_40;
    // timing: clock 20 ns, 1 ms tick, 10 s baud supervision
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned BAUD_S = 10;
    localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;
    localparam int unsigned BAUD_CYC = BAUD_S * 1000 * CYC_PER_MS;
endpackage

// >>> design/dsf_tmo.sv
`timescale 1ns/100ps
`default_nettype none
module dsf_tmo #(
    parameter int W = 32
)(
    input wire logic sys_clk_i, // system clock
    input wire logic rst_i, // async reset, high
    input wire logic ce_i, // clock enable
    input wire logic run_i, // supervision active
    input wire logic kick_i, // restart the timeout
    input wire logic [W-1:0] limit_i, // cycles, zero disables
    output logic expired_o // timeout reached, level
);
    import dsf_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic exp;
    } dsf_tmo_type;

    dsf_tmo_type r;
    dsf_tmo_type n;

    // count cycles since last kick
    always_comb begin
        n = r;
        if (!run_i || limit_i == '0 || kick_i) begin
            n.cnt = '0;
            n.exp = 1'b0;
        end else if (!r.exp) begin
            if (r.cnt == limit_i - W'(1)) begin
                n.exp = 1'b1; // [RL15]
            end else begin
                n.cnt = r.cnt + W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= n;
        end
    end

    assign expired_o = r.exp;
endmodule
`default_nettype wire

// >>> design/dsf_startup_check.sv
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RL1] start-up fault shown on LED and in diagnostic frame
// [RL2] start-up fault is error code plus argument
// [RL3] bad parameter bit: code 1, byte offset plus one
// [RL4] code 3: hold with sync 1, sync without outputs 8
// [RL5] code 3: optimized input 10, fast free-run 12, multi unchecked 6
// [RL6] code 3: undefined acyclic connection 2, buffer too big 11
// [RL7] bad configuration byte: code 2, byte offset plus one
// [RL8] output length code 5, input 6, argument expected bytes
// [RL9] code 7: length 1, syntax 2, input 3, output 4
// [RL10] code 7: max input 13, max output 14, diagnostic length 15
// [RL11] code 7: configuration length 16, parameter length 17
// [RL12] buffer over dual-port RAM: code 8, excess over 8, comms off
// [RL13] too many modules: code 9, input 1, output 2, config 3
// [RL14] terminal write fault code 10, timeout 11, argument terminal
// [RL15] fieldbus failure on watchdog or baud timeout
// [RL16] fieldbus reaction: 00 abandon, 01 zero outputs, 10 hold
// [RL17] terminal-bus error: 00 abandon, 01 zero inputs, 10 hold
// [RL18] terminal-bus error left manually, or automatically if set
// [RL19] code in diagnostic byte 14, argument in 15
// [RL20] master resets terminal bus by acyclic write
// [RL21] code and argument held until next start-up attempt
module dsf_startup_check #(
    parameter int unsigned CYC_PER_MS = dsf_pkg::CYC_PER_MS,
    parameter int unsigned BAUD_CYC = dsf_pkg::BAUD_CYC
)(
    input wire logic sys_clk_i, // system clock
    input wire logic rst_i, // async reset, high
    input wire logic ce_i, // clock enable
    input wire logic hsel_i, // ahb select
    input wire logic [31:0] haddr_i, // ahb address
    input wire logic [1:0] htrans_i, // ahb transfer type
    input wire logic hwrite_i, // ahb write
    input wire logic [2:0] hsize_i, // ahb size
    input wire logic [31:0] hwdata_i, // ahb write data
    input wire logic hready_i, // ahb bus ready
    output logic [31:0] hrdata_o, // ahb read data
    output logic hreadyout_o, // ahb slave ready
    output logic hresp_o, // ahb response
    input wire logic dp_frame_i, // valid frame from master
    input wire logic dp_traffic_i, // any bus traffic seen
    input wire logic tbus_fault_i, // terminal bus fault level
    output logic fb_led_err_o, // fieldbus error led
    output logic [7:0] diag_code_o, // diagnostic byte 14
    output logic [7:0] diag_arg_o, // diagnostic byte 15
    output logic dp_comm_en_o, // dp communication on
    output logic fb_fail_o, // fieldbus failure
    output logic tcyc_stop_o, // stop terminal cycle
    output logic subst_load_o, // load substitute values
    output logic out_zero_o, // zero outputs
    output logic out_hold_o, // hold outputs
    output logic tbus_err_o, // terminal bus error state
    output logic dx_abandon_o, // abandon dp exchange
    output logic in_zero_o, // zero dp inputs
    output logic in_hold_o, // hold dp inputs
    output logic stat_diag_o // static diagnosis flag
);
    import dsf_pkg::*;

    typedef struct packed {
        logic wr_pend;
        logic rd_pend;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic [PRM_W-1:0] prm;
        logic [23:0] len;
        logic [31:0] iolen;
        logic [18:0] lim;
        logic [31:0] bufsz;
        logic [15:0] wd_ms;
        logic [7:0] code;
        logic [7:0] arg;
        logic valid;
        logic dp_en;
        logic tb_err;
        logic stat_pend;
        logic stat_diag;
    } dsf_state_type;

    dsf_state_type r;
    dsf_state_type n;

    //////////////////////////////
    // fieldbus supervision timers

    logic wd_exp;
    logic baud_exp;
    logic [31:0] wd_lim;
    logic fail;

    assign wd_lim = 32'(r.wd_ms * CYC_PER_MS);

    dsf_tmo #(.W(32)) u_wdog (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(r.dp_en),
        .kick_i(dp_frame_i),
        .limit_i(wd_lim),
        .expired_o(wd_exp)
    );

    dsf_tmo #(.W(32)) u_baud (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(1'b1),
        .kick_i(dp_traffic_i),
        .limit_i(32'(BAUD_CYC)),
        .expired_o(baud_exp)
    );

    assign fail = wd_exp || baud_exp; // [RL15]

    //////////////////////////////
    // start-up checks

    logic [1:0] fb_re;
    logic [1:0] tb_re;
    logic [7:0] plen, clen, dlen;
    logic [7:0] oc, oe, ic, ie;
    logic [16:0] excess;
    logic over;
    logic [7:0] ex8;
    logic [7:0] ck_code, ck_arg;
    logic [7:0] bt_code, bt_arg;

    assign fb_re = r.prm[P_FB_LO+:2];
    assign tb_re = r.prm[P_TB_LO+:2];
    assign {dlen, clen, plen} = r.len;
    assign {ie, ic, oe, oc} = r.iolen;
    assign excess = {1'b0, r.bufsz[15:0]} - {1'b0, r.bufsz[31:16]};
    assign over = r.bufsz[15:0] > r.bufsz[31:16];
    assign ex8 = (excess[16:3] > 14'h00FF) ? 8'hFF : excess[10:3];

    // parameter check, first fault wins
    always_comb begin
        ck_code = 8'h00;
        ck_arg = 8'h00;
        if (plen < PRM_MIN || plen > PRM_MAX) begin
            {ck_code, ck_arg} = {C_CFGGEN, A7_PRMLEN}; // [RL11]
        end else if (clen < CFG_MIN || clen > CFG_MAX) begin
            {ck_code, ck_arg} = {C_CFGGEN, A7_CFGLEN}; // [RL11]
        end else if (dlen < DIAG_MIN || dlen > DIAG_MAX) begin
            {ck_code, ck_arg} = {C_CFGGEN, A7_DIAG}; // [RL10]
        end else if (fb_re == 2'h3 || tb_re == 2'h3) begin
            {ck_code, ck_arg} = {C_PRM, REACT_BYTE + 8'h01}; // [RL3]
        end else if (r.prm[P_SYNC] && fb_re == R_HOLD) begin
            {ck_code, ck_arg} = {C_COMBO, A3_HOLD}; // [RL4]
        end else if (r.prm[P_C1EN] && !r.prm[P_C1DEF]) begin
            {ck_code, ck_arg} = {C_COMBO, A3_C1}; // [RL6]
        end else if (r.prm[P_MULTI] && r.prm[P_NOCHK]) begin
            {ck_code, ck_arg} = {C_COMBO, A3_MULTI}; // [RL5]
        end else if (r.prm[P_SYNC] && oc == 8'h00) begin
            {ck_code, ck_arg} = {C_COMBO, A3_SYNC}; // [RL4]
        end else if (r.prm[P_OPT] && !r.prm[P_SYNC]) begin
            {ck_code, ck_arg} = {C_COMBO, A3_OPT}; // [RL5]
        end else if (r.prm[P_FAST] && r.prm[P_SYNC]) begin
            {ck_code, ck_arg} = {C_COMBO, A3_FAST}; // [RL5]
        end else if (over) begin
            {ck_code, ck_arg} = {C_COMBO, A3_BUF}; // [RL6]
        end else if (!r.prm[P_NOCHK] && oc != oe) begin
            {ck_code, ck_arg} = {C_OUTLEN, oe}; // [RL8]
        end else if (!r.prm[P_NOCHK] && ic != ie) begin
            {ck_code, ck_arg} = {C_INLEN, ie}; // [RL8]
        end else if (ic > r.lim[7:0]) begin
            {ck_code, ck_arg} = {C_CFGGEN, A7_MAXIN}; // [RL10]
        end else if (oc > r.lim[15:8]) begin
            {ck_code, ck_arg} = {C_CFGGEN, A7_MAXOUT}; // [RL10]
        end
    end

    // boot check
    always_comb begin
        bt_code = 8'h00;
        bt_arg = 8'h00;
        if (r.lim[16]) begin
            {bt_code, bt_arg} = {C_BOOT, A9_IN}; // [RL13]
        end else if (r.lim[17]) begin
            {bt_code, bt_arg} = {C_BOOT, A9_OUT}; // [RL13]
        end else if (r.lim[18]) begin
            {bt_code, bt_arg} = {C_BOOT, A9_CFG}; // [RL13]
        end else if (over) begin
            {bt_code, bt_arg} = {C_BUF, ex8}; // [RL12]
        end
    end

    //////////////////////////////
    // ahb read mux

    logic [31:0] rd_val;

    always_comb begin
        unique case (r.addr)
            A_CTRL: rd_val = {27'h0, r.stat_diag, r.tb_err, fail,
                              r.dp_en, r.valid};
            A_PRM: rd_val = {20'h0, r.prm};
            A_LEN: rd_val = {8'h00, r.len};
            A_IOLEN: rd_val = r.iolen;
            A_LIMIT: rd_val = {13'h0, r.lim};
            A_BUF: rd_val = r.bufsz;
            A_RESULT: rd_val = {16'h0, r.arg, r.code};
            A_WDOG: rd_val = {16'h0, r.wd_ms};
            default: rd_val = 32'h0;
        endcase
    end

    //////////////////////////////
    // next state

    logic aph, go_chk, go_boot, tb_rst, rep_wr, set_pend;
    logic [7:0] rep_code, rep_arg;

    always_comb begin
        n = r;
        aph = hsel_i && htrans_i[1] && hready_i;
        go_chk = 1'b0;
        go_boot = 1'b0;
        tb_rst = 1'b0;
        rep_wr = 1'b0;
        rep_code = hwdata_i[15:8];
        rep_arg = hwdata_i[7:0];
        // write data phase
        if (r.wr_pend) begin
            unique case (r.addr)
                A_CTRL: begin
                    go_chk = hwdata_i[0];
                    go_boot = hwdata_i[1];
                    tb_rst = hwdata_i[2]; // [RL20]
                end
                A_PRM: n.prm = hwdata_i[PRM_W-1:0];
                A_LEN: n.len = hwdata_i[23:0];
                A_IOLEN: n.iolen = hwdata_i;
                A_LIMIT: n.lim = hwdata_i[18:0];
                A_BUF: n.bufsz = hwdata_i;
                A_REPORT: rep_wr = 1'b1;
                A_WDOG: n.wd_ms = hwdata_i[15:0];
                default: ;
            endcase
        end
        // read data registered in first data phase
        if (r.rd_pend) begin
            n.rdata = rd_val;
        end
        n.rd_pend = aph && !hwrite_i;
        n.wr_pend = aph && hwrite_i;
        if (aph) begin
            n.addr = haddr_i[7:0];
        end
        // a start attempt replaces the held result
        if (go_chk) begin
            n.code = ck_code; // [RL2]
            n.arg = ck_arg; // [RL19]
            n.valid = ck_code != 8'h00;
        end else if (go_boot) begin
            n.code = bt_code;
            n.arg = bt_arg;
            n.valid = bt_code != 8'h00;
            n.dp_en = !over; // [RL12]
        end else if (rep_wr && !r.valid) begin
            // first fault kept until next attempt
            n.valid = rep_code != 8'h00; // [RL21]
            n.code = rep_code;
            if (rep_code == C_PRM || rep_code == C_CFG) begin
                n.arg = rep_arg + 8'h01; // [RL3] [RL7]
            end else begin
                n.arg = rep_arg; // [RL9] [RL14]
            end
        end
        // terminal-bus error state
        set_pend = tbus_fault_i && !r.tb_err && tb_re == R_ABANDON;
        if (tbus_fault_i) begin
            n.tb_err = 1'b1; // [RL17]
        end else if (r.tb_err && (r.prm[P_AUTO] || tb_rst)) begin
            n.tb_err = 1'b0; // [RL18]
        end
        if (go_chk) begin
            n.stat_diag = r.stat_pend || set_pend; // [RL17]
        end
        n.stat_pend = set_pend || (r.stat_pend && !go_chk);
    end

    //////////////////////////////
    // state register

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.len <= LEN_RST;
            r.wd_ms <= WD_DEF_MS;
            r.dp_en <= 1'b1;
        end else if (ce_i) begin
            r <= n;
        end
    end

    //////////////////////////////
    // outputs

    assign hrdata_o = r.rdata;
    assign hreadyout_o = !r.rd_pend;
    assign hresp_o = 1'b0;
    assign fb_led_err_o = r.valid || fail; // [RL1]
    assign diag_code_o = r.code; // [RL19]
    assign diag_arg_o = r.arg; // [RL19]
    assign dp_comm_en_o = r.dp_en;
    assign fb_fail_o = fail;
    // fieldbus failure reaction
    assign tcyc_stop_o = fail && fb_re[1] == fb_re[0]; // [RL16]
    assign subst_load_o = tcyc_stop_o;
    assign out_zero_o = fail && fb_re == R_ZERO; // [RL16]
    assign out_hold_o = fail && fb_re == R_HOLD; // [RL16]
    // terminal-bus failure reaction
    assign tbus_err_o = r.tb_err;
    assign dx_abandon_o = (r.tb_err && tb_re == R_ABANDON) || r.stat_diag;
    assign in_zero_o = r.tb_err && tb_re == R_ZERO; // [RL17]
    assign in_hold_o = r.tb_err && tb_re == R_HOLD; // [RL17]
    assign stat_diag_o = r.stat_diag;

    //////////////////////////////
    // checks

    logic ast_go;
    assign ast_go = ce_i && (go_chk || go_boot);

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    AST_LED: assert property (r.valid |-> fb_led_err_o) // [RL1]
        else $error("led off");
    AST_PAIR: assert property (r.valid |-> diag_code_o != 8'h00) // [RL2]
        else $error("fault without code");
    AST_PRM_ARG: assert property (ce_i && rep_wr && !r.valid
        && rep_code == C_PRM |=> diag_arg_o == $past(rep_arg) + 8'h01
        && diag_code_o == C_PRM) // [RL3]
        else $error("code 1 argument wrong");
    AST_HOLD: assert property (ce_i && go_chk ##1
        (r.code == C_COMBO && r.arg == A3_HOLD)
        |-> $past(r.prm[P_SYNC]) && $past(fb_re) == R_HOLD) // [RL4]
        else $error("code 3 arg 1 without cause");
    AST_OUTLEN: assert property (ce_i && go_chk && ck_code == C_OUTLEN
        |=> diag_arg_o == $past(oe)) // [RL8]
        else $error("code 5 argument");
    AST_BUF: assert property (ce_i && go_boot && !r.lim[16] && !r.lim[17]
        && !r.lim[18] && over |=> !dp_comm_en_o && diag_code_o == C_BUF)
        // [RL12]
        else $error("comms left on");
    AST_FBZERO: assert property (fail && fb_re == R_ZERO
        |-> out_zero_o && !out_hold_o && !tcyc_stop_o) // [RL16]
        else $error("zero reaction wrong");
    AST_TBERR: assert property (ce_i && tbus_fault_i |=> tbus_err_o) // [RL17]
        else $error("terminal fault not entered");
    AST_MANUAL: assert property (ce_i && r.tb_err && !r.prm[P_AUTO]
        && !tb_rst |=> tbus_err_o) // [RL18]
        else $error("left without reset");
    AST_HOLDRES: assert property (!ast_go && r.valid
        |=> $stable(diag_code_o) && $stable(diag_arg_o)) // [RL21]
        else $error("reported fault changed");

    COV_COMBO: cover property (go_chk && ck_code == C_COMBO);
    COV_BOOT: cover property (go_boot && bt_code == C_BUF);
    COV_FAIL: cover property ($rose(fb_fail_o));
    COV_TBEXIT: cover property (r.tb_err ##1 !r.tb_err);
endmodule
`default_nettype wire

// >>> tb/dsf_dp_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsf_dp_master_model (
    input wire logic sys_clk_i, // system clock
    input wire logic rst_i, // async reset, high
    input wire logic frames_on_i, // master sends frames
    input wire logic traffic_on_i, // other bus traffic
    output logic frame_o, // valid frame pulse
    output logic traffic_o // traffic pulse
);
    logic [2:0] cnt_r;

    //////////////////////////////
    // a frame every eight cycles while on
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 3'h0;
            frame_o <= 1'b0;
            traffic_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            frame_o <= frames_on_i && (cnt_r == 3'h7);
            traffic_o <= (frames_on_i || traffic_on_i) && (cnt_r == 3'h7);
        end
    end
endmodule
`default_nettype wire

// >>> tb/dsf_startup_check_test.sv
`timescale 1ns/100ps
`default_nettype none
module dsf_startup_check_test;
    import dsf_pkg::*;
    localparam logic [31:0] L0 = 32'h0040_0140;
    localparam logic [31:0] M0 = 32'h0000_FFFF;
    localparam logic [31:0] B0 = 32'h0100_0010;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
    logic tbus_fault_i = 1'b0, frames_on = 1'b1, traffic_on = 1'b1;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
    logic [1:0] htrans_i = 2'h0;
    logic hreadyout_o, hresp_o, fb_led_err_o, dp_comm_en_o, fb_fail_o;
    logic tcyc_stop_o, subst_load_o, out_zero_o, out_hold_o, tbus_err_o;
    logic dx_abandon_o, in_zero_o, in_hold_o, stat_diag_o, frm, trf;
    logic [7:0] diag_code_o, diag_arg_o;
    int bad_count = 0, cmp_count = 0;

    //////////////////////////////
    // clock, design and master model
    always #10 sys_clk_i = ~sys_clk_i;
    dsf_startup_check #(.CYC_PER_MS(4), .BAUD_CYC(200)) i_dut (
        .sys_clk_i, .rst_i, .ce_i(1'b1), .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
        .hrdata_o, .hreadyout_o, .hresp_o, .dp_frame_i(frm),
        .dp_traffic_i(trf), .tbus_fault_i, .fb_led_err_o, .diag_code_o,
        .diag_arg_o, .dp_comm_en_o, .fb_fail_o, .tcyc_stop_o,
        .subst_load_o, .out_zero_o, .out_hold_o, .tbus_err_o,
        .dx_abandon_o, .in_zero_o, .in_hold_o, .stat_diag_o);
    dsf_dp_master_model i_master (.sys_clk_i, .rst_i,
        .frames_on_i(frames_on), .traffic_on_i(traffic_on),
        .frame_o(frm), .traffic_o(trf));

    //////////////////////////////
    // helpers
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // single transfer, each phase held until ready
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= w;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge sys_clk_i);
                n++;
            end while (hreadyout_o !== 1'b1 && n < 50);
            if (n >= 50) begin
                bad_count++;
                report_and_stop;
            end
            htrans_i <= 2'h0;
            hwdata_i <= d;
        end
        rd = hrdata_o;
        hsel_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wait_fb(input logic v, output int n);
        n = 0;
        while (fb_fail_o !== v && n < 300) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 300) begin
            bad_count++;
            report_and_stop;
        end
    endtask
    // load and run the check, compare the result
    task automatic cse(input logic [11:0] p, input logic [31:0] l, io,
        lm, bf, input logic [15:0] e);
        wr(A_PRM, {20'h0, p});
        wr(A_LEN, l);
        wr(A_IOLEN, io);
        wr(A_LIMIT, lm);
        wr(A_BUF, bf);
        wr(A_CTRL, 32'h1);
        @(negedge sys_clk_i);
        chk({16'h0, diag_code_o, diag_arg_o}, {16'h0, e}); // pair
        chk({31'h0, fb_led_err_o}, {31'h0, e != 16'h0}); // led
        rdc(A_RESULT, {16'h0, e[7:0], e[15:8]}); // readback
    endtask
    task automatic rep(input logic [15:0] w, input logic [15:0] e);
        cse(12'h0, L0, 32'h0, M0, B0, 16'h0);
        wr(A_REPORT, {16'h0, w});
        @(negedge sys_clk_i);
        chk({16'h0, diag_code_o, diag_arg_o}, {16'h0, e});
    endtask

    //////////////////////////////
    // scenarios
    task automatic t_regs;
        chk({21'h0, dp_comm_en_o, fb_fail_o, hresp_o, diag_code_o}, 32'h400);
        rdc(A_LEN, L0);
        rdc(A_WDOG, 32'h64);
        rdc(A_PRM, 32'h0);
        wr(8'h24, 32'hFFFF_FFFF);
        rdc(8'h24, 32'h0);
        wr(A_WDOG, 32'h0001_0005);
        rdc(A_WDOG, 32'h5);
        $display("registers done");
    endtask
    task automatic t_prm;
        cse(12'h000, 32'h0010F0E0, 0, M0, B0, 16'h0000); // edges
        cse(12'h000, 32'h0040013F, 0, M0, B0, 16'h0711); // short
        cse(12'h000, 32'h004001E1, 0, M0, B0, 16'h0711); // long
        cse(12'h000, 32'h00400040, 0, M0, B0, 16'h0710); // cfg
        cse(12'h000, 32'h0040F140, 0, M0, B0, 16'h0710); // cfg
        cse(12'h000, 32'h000F0140, 0, M0, B0, 16'h070F); // diag
        cse(12'h000, 32'h00410140, 0, M0, B0, 16'h070F); // diag
        cse(12'h003, L0, 0, M0, B0, 16'h010B); // reserved
        cse(12'h022, L0, 32'h101, M0, B0, 16'h0301); // hold
        cse(12'h020, L0, 0, M0, B0, 16'h0308); // no outputs
        cse(12'h400, L0, 0, M0, B0, 16'h0302); // acyclic
        cse(12'hC00, L0, 0, M0, B0, 16'h0000); // acyclic ok
        cse(12'h300, L0, 0, M0, B0, 16'h0306); // multi
        cse(12'h040, L0, 0, M0, B0, 16'h030A); // optimized
        cse(12'h0A0, L0, 32'h101, M0, B0, 16'h030C); // fast
        cse(12'h000, L0, 0, M0, 32'h00100020, 16'h030B); // buffer
        cse(12'h000, L0, 32'h201, M0, B0, 16'h0502); // outputs
        cse(12'h000, L0, 32'h03000000, M0, B0, 16'h0603); // inputs
        cse(12'h200, L0, 32'h201, M0, B0, 16'h0000); // check off
        cse(12'h000, L0, 32'h101, 32'hFF, B0, 16'h070E); // max out
        cse(12'h000, L0, 32'h01010000, 32'hFF00, B0, 16'h070D);
        $display("parameter checks done");
    endtask
    task automatic t_rep;
        rep(16'h0A03, 16'h0A03); // register fault
        rep(16'h0B02, 16'h0B02); // timeout
        rep(16'h0104, 16'h0105); // offset plus one
        rep(16'h0203, 16'h0204); // offset plus one
        for (int i = 1; i < 5; i++) begin
            rep({8'h07, 8'(i)}, {8'h07, 8'(i)}); // general
        end
        wr(A_REPORT, 32'h0B07);
        @(negedge sys_clk_i);
        chk({16'h0, diag_code_o, diag_arg_o}, 32'h0704); // kept
        $display("reports done");
    endtask
    task automatic t_fb;
        int n;
        for (int r = 0; r < 3; r++) begin
            wr(A_PRM, r);
            wr(A_WDOG, 32'hA);
            frames_on <= 1'b0;
            repeat (30) @(posedge sys_clk_i);
            chk({31'h0, fb_fail_o}, 32'h0); // not yet
            wait_fb(1'b1, n);
            chk({31'h0, n <= 20}, 32'h1); // watchdog
            @(negedge sys_clk_i);
            chk({28'h0, tcyc_stop_o, subst_load_o, out_zero_o, out_hold_o},
                r == 0 ? 32'hC : r == 1 ? 32'h2 : 32'h1); // reaction
            chk({31'h0, fb_led_err_o}, 32'h1); // led
            frames_on <= 1'b1;
            wait_fb(1'b0, n);
        end
        wr(A_WDOG, 32'h0);
        frames_on <= 1'b0;
        traffic_on <= 1'b0;
        repeat (180) @(posedge sys_clk_i);
        chk({31'h0, fb_fail_o}, 32'h0); // not yet
        wait_fb(1'b1, n);
        chk({31'h0, n <= 40}, 32'h1); // baud time
        frames_on <= 1'b1;
        traffic_on <= 1'b1;
        wait_fb(1'b0, n);
        $display("fieldbus failure done");
    endtask
    task automatic t_tb;
        for (int r = 0; r < 3; r++) begin
            wr(A_PRM, r << 2);
            tbus_fault_i <= 1'b1;
            @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            chk({28'h0, tbus_err_o, dx_abandon_o, in_zero_o, in_hold_o},
                r == 0 ? 32'hC : r == 1 ? 32'hA : 32'h9); // react
            @(posedge sys_clk_i);
            tbus_fault_i <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
            chk({31'h0, tbus_err_o}, 32'h1); // stays
            wr(A_CTRL, 32'h4); // manual reset
            @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            chk({31'h0, tbus_err_o}, 32'h0); // manual exit
        end
        wr(A_PRM, 32'h18);
        tbus_fault_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        tbus_fault_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk({31'h0, tbus_err_o}, 32'h0); // automatic exit
        cse(12'h008, L0, 32'h0, M0, B0, 16'h0);
        chk({30'h0, stat_diag_o, dx_abandon_o}, 32'h3); // flag
        cse(12'h008, L0, 32'h0, M0, B0, 16'h0);
        chk({31'h0, stat_diag_o}, 32'h0); // flag gone
        $display("terminal bus done");
    endtask
    task automatic t_boot;
        for (int i = 0; i < 3; i++) begin
            wr(A_LIMIT, M0 | (32'h1 << (16 + i)));
            wr(A_CTRL, 32'h2);
            @(negedge sys_clk_i);
            chk({diag_code_o, diag_arg_o}, {8'h09, 8'(i + 1)}); // boot
        end
        wr(A_LIMIT, M0);
        wr(A_BUF, 32'h0010_0040);
        wr(A_CTRL, 32'h2);
        @(negedge sys_clk_i);
        chk({15'h0, dp_comm_en_o, diag_code_o, diag_arg_o}, 32'h0806);
        $display("boot checks done");
    endtask

    //////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_prm;
        t_rep;
        t_fb;
        t_tb;
        t_boot;
        report_and_stop;
    end
endmodule
`default_nettype wire
